// ---- rtl/smisc_pkg.sv ----
/*
  Constants, register map and types of the serial channel in its two-wire bus mode.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses and registers of at most 9 bits.
*/
package smisc_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFF_MODE = 16'hff60;
  localparam logic [15:0] OFF_SLAVE_ADDR = 16'hff64;
  localparam logic [15:0] OFF_SHIFT = 16'hff68;
  localparam logic [15:0] OFF_BUS_CTRL = 16'hff6c;
  localparam logic [15:0] OFF_TIMER_CLK_SEL = 16'hff70;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] IDLE_SHIFT = 8'hff;
  // Mode register fields
  localparam int MODE_ENABLE = 7;
  localparam int MODE_MATCH = 6;
  localparam int MODE_WAKEUP = 5;
  localparam int MODE_SEL_HI = 4;
  localparam int MODE_SEL_MID = 3;
  localparam int MODE_PIN_SEL = 2;
  localparam int MODE_CLK_HI = 1;
  localparam int MODE_CLK_LO = 0;
  // Bus control register fields
  localparam int BC_STOP_CMD = 0;
  localparam int BC_START_CMD = 1;
  localparam int BC_STOP_SEEN = 2;
  localparam int BC_START_SEEN = 3;
  localparam int BC_ACK_EN = 4;
  localparam int BC_WAIT_EN = 5;
  localparam int BC_ACK_SEEN = 6;
  localparam int BC_BUSY = 7;
  localparam int BC_DIR = 8;
  localparam int TCL_W = 4;
  localparam int TIMER_DIV = 16;
  localparam logic [3:0] LAST_DATA_BIT = 4'h8;
  localparam logic [3:0] ACK_BIT = 4'h9;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    SMISC_IDLE = 3'b001,
    SMISC_SHIFT = 3'b010,
    SMISC_WAIT = 3'b100
  } smisc_state_e;
endpackage

// ---- rtl/smisc_line_if.sv ----
/*
  Bus line levels and events passed from the line monitor to the channel core.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/100ps
interface smisc_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport mon (output scl, sda, scl_rise, scl_fall, start, stop);
  modport core (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface

// ---- rtl/smisc_line_monitor.sv ----
/*
  Synchronises the clock and data lines and finds edges, start and stop conditions.
  Assumes raw pin levels from outside the clock domain.
*/
`timescale 1ns/100ps
module smisc_line_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_pin,
  input wire logic sda_pin,
  smisc_line_if.mon line
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_prev;
  logic sda_prev;

  // Lines idle high, so the synchronisers reset high to avoid false events
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_pin};
      sda_sync <= {sda_sync[0], sda_pin};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  assign line.scl = scl_sync[1];
  assign line.sda = sda_sync[1];
  assign line.scl_rise = !scl_prev && scl_sync[1];
  assign line.scl_fall = scl_prev && !scl_sync[1];
  assign line.start = scl_prev && scl_sync[1] && sda_prev && !sda_sync[1];
  assign line.stop = scl_prev && scl_sync[1] && !sda_prev && sda_sync[1];
endmodule // smisc_line_monitor

// ---- rtl/smisc_channel.sv ----
/*
  Serial channel in two-wire bus mode: register file on AXI4-Lite, shift engine,
  address compare, acknowledge, wait stretching and bus clock generation.
  Assumes external pull-ups resolve the open-drain lines and clock sources are async.
*/
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/100ps
// Operation
// - Data fall with clock high is start
// - Data rise with clock high is stop
// - Seven bits after start are address
// - Only matching slave joins until start/stop
// - Bit after address gives direction
// - Receiver acknowledges each byte, master skips last
// - Master drives start, address, stop, clock
// - Slave holds clock low to wait
// - Wake-up interrupts on match and stop
// - Wake-up off: interrupt every transfer
// - Channel enable stops or runs channel
// - Read-only flag shows address equals shift
// - Mode bits pick wire mode and pin
// - Clock field picks pin, timer, prescaler
// - Mode register resets to zero
// - Timer clock divided by sixteen
// - Start command clears latch, self-clears
module smisc_channel #(
  parameter int DIV = smisc_pkg::TIMER_DIV
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic first_data_pin_in,
  output logic first_data_pin_out,
  output logic first_data_pin_oe,
  input wire logic second_data_pin_in,
  output logic second_data_pin_out,
  output logic second_data_pin_oe,
  input wire logic timer_two_output,
  input wire logic [15:0] prescaler_taps,
  output logic transfer_irq
);
  logic [7:0] serial_mode_control;
  logic [7:0] slave_address_register;
  logic [7:0] serial_shift_register;
  logic [3:0] timer_clock_select_three;
  logic start_output_command;
  logic stop_output_command;
  logic start_detected_flag;
  logic stop_seen;
  logic ack_enable;
  logic wait_enable;
  logic ack_seen;
  logic direction;
  logic out_latch;
  logic active;
  logic addr_phase;
  logic addr_match;
  logic done;
  logic [3:0] bit_count;
  smisc_pkg::smisc_state_e state;
  logic gen_scl;
  logic [1:0] timer_sync;
  logic timer_prev;
  logic [1:0] tap_sync;
  logic tap_prev;
  logic [3:0] div_count;
  logic tick;
  logic [15:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic wr_fire;
  logic [31:0] rd_word;
  logic rd_ok;
  logic channel_enable;
  logic two_wire;
  logic ext_clk;
  logic shift_write;
  logic match_now;
  logic ack_drive;
  logic data_oe;
  smisc_line_if line ();

  assign channel_enable = serial_mode_control[smisc_pkg::MODE_ENABLE];
  assign two_wire = serial_mode_control[smisc_pkg::MODE_SEL_HI]
                 && serial_mode_control[smisc_pkg::MODE_SEL_MID];
  assign ext_clk = !serial_mode_control[smisc_pkg::MODE_CLK_HI];

  smisc_line_monitor u_mon (
    .clk(clk),
    .rst_b(rst_b),
    .scl_pin(scl_in),
    .sda_pin(serial_mode_control[smisc_pkg::MODE_PIN_SEL] ? first_data_pin_in
             : second_data_pin_in),
    .line(line)
  );

  // Register bus: address and data may arrive in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign shift_write = wr_fire && w_strb[0] && aw_addr == smisc_pkg::OFF_SHIFT
                    && channel_enable;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 16'h0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= smisc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == smisc_pkg::OFF_MODE || aw_addr == smisc_pkg::OFF_SLAVE_ADDR
                        || aw_addr == smisc_pkg::OFF_SHIFT || aw_addr == smisc_pkg::OFF_BUS_CTRL
                        || aw_addr == smisc_pkg::OFF_TIMER_CLK_SEL)
                       ? smisc_pkg::RESP_OKAY : smisc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      smisc_pkg::OFF_MODE: begin
        rd_word[7:0] = serial_mode_control;
        rd_word[smisc_pkg::MODE_MATCH] = channel_enable
                                         && slave_address_register == serial_shift_register;
      end
      smisc_pkg::OFF_SLAVE_ADDR: rd_word[7:0] = slave_address_register;
      smisc_pkg::OFF_SHIFT: rd_word[7:0] = serial_shift_register;
      smisc_pkg::OFF_BUS_CTRL: begin
        rd_word[smisc_pkg::BC_STOP_SEEN] = stop_seen;
        rd_word[smisc_pkg::BC_START_SEEN] = start_detected_flag;
        rd_word[smisc_pkg::BC_ACK_EN] = ack_enable;
        rd_word[smisc_pkg::BC_WAIT_EN] = wait_enable;
        rd_word[smisc_pkg::BC_ACK_SEEN] = ack_seen;
        rd_word[smisc_pkg::BC_BUSY] = state != smisc_pkg::SMISC_IDLE;
        rd_word[smisc_pkg::BC_DIR] = direction;
      end
      smisc_pkg::OFF_TIMER_CLK_SEL: rd_word[3:0] = timer_clock_select_three;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= smisc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? smisc_pkg::RESP_OKAY : smisc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Configuration registers; the match bit is never stored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_mode_control <= smisc_pkg::RESET_BYTE;
      slave_address_register <= smisc_pkg::RESET_BYTE;
      timer_clock_select_three <= 4'h0;
      ack_enable <= 1'b0;
      wait_enable <= 1'b0;
    end else if (wr_fire && w_strb[0]) begin
      if (aw_addr == smisc_pkg::OFF_MODE) begin
        serial_mode_control <= w_data[7:0] & ~(8'h01 << smisc_pkg::MODE_MATCH);
      end
      if (aw_addr == smisc_pkg::OFF_SLAVE_ADDR) begin
        slave_address_register <= w_data[7:0];
      end
      if (aw_addr == smisc_pkg::OFF_TIMER_CLK_SEL) begin
        timer_clock_select_three <= w_data[3:0];
      end
      if (aw_addr == smisc_pkg::OFF_BUS_CTRL) begin
        ack_enable <= w_data[smisc_pkg::BC_ACK_EN];
        wait_enable <= w_data[smisc_pkg::BC_WAIT_EN];
      end
    end
  end

  // Command bits live one cycle, then clear themselves
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      start_output_command <= 1'b0;
      stop_output_command <= 1'b0;
    end else begin
      start_output_command <= wr_fire && w_strb[0] && channel_enable
                              && aw_addr == smisc_pkg::OFF_BUS_CTRL
                              && w_data[smisc_pkg::BC_START_CMD];
      stop_output_command <= wr_fire && w_strb[0] && channel_enable
                             && aw_addr == smisc_pkg::OFF_BUS_CTRL
                             && w_data[smisc_pkg::BC_STOP_CMD];
    end
  end

  // Internal bus clock sources: timer output divided, or a selected prescaler tap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_sync <= 2'b00;
      timer_prev <= 1'b0;
      tap_sync <= 2'b00;
      tap_prev <= 1'b0;
      div_count <= 4'h0;
    end else begin
      timer_sync <= {timer_sync[0], timer_two_output};
      timer_prev <= timer_sync[1];
      tap_sync <= {tap_sync[0], prescaler_taps[timer_clock_select_three]};
      tap_prev <= tap_sync[1];
      if (timer_sync[1] && !timer_prev) begin
        div_count <= (div_count == 4'((DIV / 2) - 1)) ? 4'h0 : div_count + 4'h1;
      end
    end
  end

  // One toggle every half period gives a bus clock of the timer rate over DIV, or half the selected prescaler tap rate
  assign tick = serial_mode_control[smisc_pkg::MODE_CLK_LO]
              ? (tap_sync[1] && !tap_prev)
              : (timer_sync[1] && !timer_prev && div_count == 4'((DIV / 2) - 1));

  // Master clock generator; a slave holding the line low delays the next low phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gen_scl <= 1'b1;
    end else if (ext_clk || state != smisc_pkg::SMISC_SHIFT) begin
      gen_scl <= 1'b1;
    end else if (tick && !gen_scl) begin
      gen_scl <= 1'b1;
    end else if (tick && line.scl) begin
      gen_scl <= 1'b0;
    end
  end

  assign match_now = serial_shift_register[7:1] == slave_address_register[7:1];
  assign ack_drive = ack_enable && (!addr_phase || match_now);

  // Shift engine: sample on clock rise, change data on clock fall
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= smisc_pkg::SMISC_IDLE;
      serial_shift_register <= smisc_pkg::RESET_BYTE;
      bit_count <= 4'h0;
      out_latch <= 1'b1;
      active <= 1'b0;
      addr_phase <= 1'b0;
      addr_match <= 1'b0;
      direction <= 1'b0;
      ack_seen <= 1'b0;
      done <= 1'b0;
    end else if (!channel_enable || !two_wire) begin
      state <= smisc_pkg::SMISC_IDLE;
      bit_count <= 4'h0;
      out_latch <= 1'b1;
      active <= 1'b0;
      addr_phase <= 1'b0;
      ack_seen <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      // Address phase clears one cycle after done is set, so wake-up and stop flag logic see it with done
      if (done) begin
        addr_phase <= 1'b0;
      end
      if (start_output_command) begin
        out_latch <= 1'b0;
      end else if (stop_output_command) begin
        out_latch <= 1'b1;
      end
      if (line.start && ext_clk) begin
        state <= smisc_pkg::SMISC_SHIFT;
        serial_shift_register <= smisc_pkg::IDLE_SHIFT;
        bit_count <= 4'h0;
        out_latch <= 1'b1;
        active <= 1'b1;
        addr_phase <= 1'b1;
        addr_match <= 1'b0;
      end else if (line.stop) begin
        state <= smisc_pkg::SMISC_IDLE;
        active <= 1'b0;
        addr_phase <= 1'b0;
        if (ext_clk) begin
          out_latch <= 1'b1;
        end
      end else if (shift_write) begin
        state <= smisc_pkg::SMISC_SHIFT;
        serial_shift_register <= w_data[7:0];
        bit_count <= 4'h0;
        out_latch <= w_data[7];
        ack_seen <= 1'b0;
      end else if (state == smisc_pkg::SMISC_SHIFT) begin
        if (line.scl_rise && bit_count < smisc_pkg::LAST_DATA_BIT) begin
          serial_shift_register <= {serial_shift_register[6:0], line.sda};
          bit_count <= bit_count + 4'h1;
        end else if (line.scl_rise && bit_count == smisc_pkg::LAST_DATA_BIT) begin
          ack_seen <= !line.sda;
          bit_count <= smisc_pkg::ACK_BIT;
        end else if (line.scl_fall && bit_count != 4'h0
                     && bit_count < smisc_pkg::LAST_DATA_BIT) begin
          out_latch <= serial_shift_register[7];
        end else if (line.scl_fall && bit_count == smisc_pkg::LAST_DATA_BIT) begin
          out_latch <= !ack_drive;
          if (addr_phase) begin
            addr_match <= match_now;
            direction <= serial_shift_register[0];
            active <= match_now;
          end
        end else if (line.scl_fall && bit_count == smisc_pkg::ACK_BIT) begin
          out_latch <= 1'b1;
          done <= 1'b1;
          state <= (ext_clk && wait_enable && active) ? smisc_pkg::SMISC_WAIT
                   : smisc_pkg::SMISC_IDLE;
        end
      end
    end
  end

  // Start flag: set on start, cleared on stop or a new transfer; set wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      start_detected_flag <= 1'b0;
      stop_seen <= 1'b0;
    end else if (!channel_enable) begin
      start_detected_flag <= 1'b0;
      stop_seen <= 1'b0;
    end else begin
      if (line.start) begin
        start_detected_flag <= 1'b1;
      end else if (line.stop || shift_write) begin
        start_detected_flag <= 1'b0;
      end
      if (line.stop) begin
        stop_seen <= 1'b1;
      end else if (shift_write || (done && addr_phase && !addr_match)) begin
        stop_seen <= 1'b0;
      end
    end
  end

  // Interrupt request pulse, qualified by wake-up
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      transfer_irq <= 1'b0;
    end else if (!serial_mode_control[smisc_pkg::MODE_WAKEUP]) begin
      transfer_irq <= done;
    end else begin
      transfer_irq <= (done && addr_phase && addr_match && start_detected_flag)
                      || (line.stop && channel_enable && two_wire);
    end
  end

  // Open-drain drive; a slave that lost the compare stays off the bus
  assign data_oe = channel_enable && two_wire && !out_latch && (active || !ext_clk);
  assign first_data_pin_out = 1'b0;
  assign second_data_pin_out = 1'b0;
  assign first_data_pin_oe = data_oe && serial_mode_control[smisc_pkg::MODE_PIN_SEL];
  assign second_data_pin_oe = data_oe && !serial_mode_control[smisc_pkg::MODE_PIN_SEL];
  assign scl_out = 1'b0;
  assign scl_oe = channel_enable && two_wire
                && ((!ext_clk && !gen_scl) || state == smisc_pkg::SMISC_WAIT);
endmodule // smisc_channel

// ---- verification/smisc_channel_sva.sv ----
/*
  Port checker of the serial channel.
  Assumes it is bound into smisc_channel and sees only its ports.
*/
`timescale 1ns/100ps
module smisc_channel_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic first_data_pin_out,
  input wire logic first_data_pin_oe,
  input wire logic second_data_pin_out,
  input wire logic second_data_pin_oe,
  input wire logic transfer_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic mapped;
  assign mapped = s_axi_araddr inside {16'hff60, 16'hff64, 16'hff68, 16'hff6c, 16'hff70};
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("no write response");
  unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready && !mapped |=> s_axi_rvalid
    && s_axi_rresp == smisc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
  irq_pulse_a: assert property (transfer_irq |=> !transfer_irq)
    else $error("interrupt longer than one cycle");
  pin_excl_a: assert property (!(first_data_pin_oe && second_data_pin_oe))
    else $error("both data pins driven");
  open_drain_a: assert property (!scl_out && !first_data_pin_out && !second_data_pin_out)
    else $error("line driven high");
  data_change_a: assert property ($changed(first_data_pin_oe) |-> !scl_in)
    else $error("data changed while clock high");
  cover property (transfer_irq);
  cover property (first_data_pin_oe && scl_in);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule // smisc_channel_sva

bind smisc_channel smisc_channel_sva i_smisc_channel_sva (.clk, .rst_b, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .scl_in, .scl_out, .first_data_pin_out, .first_data_pin_oe, .second_data_pin_out,
  .second_data_pin_oe, .transfer_irq);

// ---- verification/smisc_mstr.sv ----
/*
  Bus master model: open-drain clock and data, start, stop, bytes.
  Assumes the bench resolves both lines with pull-ups.
*/
`timescale 1ns/100ps
module smisc_mstr #(
  parameter int HALF = 12
) (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low,
  output logic stall
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stall = 1'b0;
  end
  task automatic gap();
    repeat (HALF) @(posedge clk);
  endtask
  // Releases the clock; a stretching slave keeps it low, so wait for the line
  task automatic clk_high();
    int n;
    n = 0;
    scl_low <= 1'b0;
    @(posedge clk);
    while (scl !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) stall <= 1'b1;
    gap();
  endtask
  task automatic start_cond();
    sda_low <= 1'b0;
    gap();
    clk_high();
    sda_low <= 1'b1;
    gap();
    scl_low <= 1'b1;
  endtask
  task automatic stop_cond();
    repeat (2) @(posedge clk);
    sda_low <= 1'b1;
    gap();
    clk_high();
    sda_low <= 1'b0;
    gap();
  endtask
  // Data moves a little after the clock fall, never with it
  task automatic put_bit(input logic b, output logic s);
    repeat (2) @(posedge clk);
    sda_low <= !b;
    gap();
    clk_high();
    s = sda;
    scl_low <= 1'b1;
  endtask
  // Ninth bit released: slave acknowledge, or none after a final read
  task automatic put_byte(input logic [7:0] b, output logic ack, output logic [7:0] rx);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], s);
      rx[i] = s;
    end
    put_bit(1'b1, s);
    ack = !s;
  endtask
endmodule // smisc_mstr

// ---- verification/tb.sv ----
/*
  Bench of the serial channel: register tasks on the bus, master model on the lines.
  Assumes pull-ups on clock and data lines.
*/
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] awaddr = 16'h0, araddr = 16'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, scl_out, scl_oe, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic d1_out, d1_oe, d2_out, d2_oe, m_scl_low, m_sda_low, stall, scl, sda;
  int err_count = 0, num_checks = 0, irqs = 0;
  assign scl = !(m_scl_low || scl_oe);
  assign sda = !(m_sda_low || d1_oe);
  always #5 clk = ~clk;
  always @(posedge clk) if (irq === 1'b1) irqs <= irqs + 1;
  smisc_channel #(.DIV(4)) i_smisc_channel (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .first_data_pin_in(sda), .first_data_pin_out(d1_out), .first_data_pin_oe(d1_oe),
    .second_data_pin_in(!d2_oe), .second_data_pin_out(d2_out), .second_data_pin_oe(d2_oe),
    .timer_two_output(1'b0), .prescaler_taps(16'h0), .transfer_irq(irq));
  smisc_mstr i_smisc_mstr (.clk(clk), .scl(scl), .sda(sda), .scl_low(m_scl_low),
    .sda_low(m_sda_low), .stall(stall));
  task automatic results();
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Ready is sampled at the falling edge, so the handshake edge is the next rising one
  task automatic axi_write(input logic [15:0] a, input logic [7:0] d);
    int n;
    logic b_hit, aw_hit, w_hit;
    n = 0;
    b_hit = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hit && n < 200) begin
      @(negedge clk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      b_hit = bvalid === 1'b1;
      @(posedge clk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    @(posedge clk);
    if (!b_hit) err_count++;
    if (!b_hit) results();
  endtask
  task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic r_hit, ar_hit;
    n = 0;
    r_hit = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hit && n < 200) begin
      @(negedge clk);
      ar_hit = arvalid && arready;
      r_hit = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_hit) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    @(posedge clk);
    if (!r_hit) err_count++;
    if (!r_hit) results();
  endtask
  task automatic rd_chk(input string what, input logic [15:0] a, input logic [31:0] mask,
    input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(what, exp, d & mask);
  endtask
  task automatic irq_chk(input int exp);
    repeat (10) @(posedge clk);
    check("interrupt count", exp, irqs);
  endtask
  initial begin
    logic ack;
    logic [7:0] rx;
    logic [31:0] d;
    logic [1:0] r;
    int base;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd_chk("mode reset", 16'hff60, 32'hff, 32'h0);
    rd_chk("bus control reset", 16'hff6c, 32'h1ff, 32'h0);
    axi_read(16'hff7c, d, r);
    check("unmapped response", {30'h0, smisc_pkg::RESP_SLVERR}, {30'h0, r});
    axi_write(16'hff60, 8'hdc);
    rd_chk("mode enabled", 16'hff60, 32'hff, 32'hdc);
    axi_write(16'hff68, 8'hff);
    axi_write(16'hff64, 8'ha4);
    axi_write(16'hff6c, 8'h30);
    rd_chk("mode no match", 16'hff60, 32'hff, 32'h9c);
    $display("Test registers done");
    i_smisc_mstr.start_cond();
    i_smisc_mstr.put_byte(8'ha4, ack, rx);
    check("address ack", 32'h1, {31'h0, ack});
    irq_chk(1);
    check("wait hold", 32'h1, {31'h0, scl_oe});
    rd_chk("start flag", 16'hff6c, 32'h138, 32'h038);
    rd_chk("address shifted", 16'hff68, 32'hff, 32'ha4);
    rd_chk("match flag", 16'hff60, 32'hff, 32'hdc);
    axi_write(16'hff68, 8'hff);
    check("wait release", 32'h0, {31'h0, scl_oe});
    i_smisc_mstr.put_byte(8'h3c, ack, rx);
    check("data ack", 32'h1, {31'h0, ack});
    irq_chk(2);
    rd_chk("data shifted", 16'hff68, 32'hff, 32'h3c);
    axi_write(16'hff68, 8'hff);
    i_smisc_mstr.stop_cond();
    rd_chk("stop flag", 16'hff6c, 32'h0c, 32'h04);
    $display("Test master write done");
    axi_write(16'hff6c, 8'h10);
    i_smisc_mstr.start_cond();
    i_smisc_mstr.put_byte(8'ha5, ack, rx);
    check("read address ack", 32'h1, {31'h0, ack});
    rd_chk("direction bit", 16'hff6c, 32'h100, 32'h100);
    axi_write(16'hff6c, 8'h00);
    axi_write(16'hff68, 8'h5a);
    i_smisc_mstr.put_byte(8'hff, ack, rx);
    check("slave data", 32'h5a, {24'h0, rx});
    i_smisc_mstr.stop_cond();
    axi_write(16'hff6c, 8'h10);
    i_smisc_mstr.start_cond();
    i_smisc_mstr.put_byte(8'h30, ack, rx);
    check("foreign address", 32'h0, {31'h0, ack});
    i_smisc_mstr.stop_cond();
    $display("Test read and refusal done");
    axi_write(16'hff60, 8'hbc);
    base = irqs;
    i_smisc_mstr.start_cond();
    i_smisc_mstr.put_byte(8'h30, ack, rx);
    irq_chk(base);
    i_smisc_mstr.stop_cond();
    irq_chk(base + 1);
    i_smisc_mstr.start_cond();
    i_smisc_mstr.put_byte(8'ha4, ack, rx);
    irq_chk(base + 2);
    i_smisc_mstr.stop_cond();
    irq_chk(base + 3);
    $display("Test wake-up done");
    axi_write(16'hff60, 8'h1c);
    i_smisc_mstr.start_cond();
    i_smisc_mstr.put_byte(8'ha4, ack, rx);
    check("disabled ack", 32'h0, {31'h0, ack});
    i_smisc_mstr.stop_cond();
    rd_chk("mode disabled", 16'hff60, 32'hff, 32'h1c);
    check("clock stall", 32'h0, {31'h0, stall});
    $display("Test disable done");
    results();
  end
endmodule // tb
